// File: core/xcvr_consts.svh
`ifndef XCVR_CONSTS_SVH
`define XCVR_CONSTS_SVH

`define CLK_MHZ      100
`define HALF_BIT_NS  500
`define HALF_CYC     ((`HALF_BIT_NS * `CLK_MHZ) / 1000)
`define SYNC_CYC     (3 * `HALF_CYC)
`define SYNC_TOL_NS  100
`define SYNC_TOL     ((`SYNC_TOL_NS * `CLK_MHZ) / 1000)
`define HALVES       40
`define LAST_BIT     5'h10
`define SYNC_CMD     6'h38
`define SYNC_DAT     6'h07

`define OFF_CTRL     8'h00
`define OFF_STAT     8'h04
`define OFF_TXA      8'h08
`define OFF_TXB      8'h0c
`define OFF_RXA      8'h10
`define OFF_RXB      8'h14

`define CTRL_RST     2'h0
`define PIN_RST      7'h07
`define PIN_STYLE    0
`define PIN_BLK      1
`define PIN_RX       3

`endif

// File: core/xcvr_pkg.sv
package xcvr_pkg;

  typedef struct packed {
    logic        cmd_sync;
    logic [15:0] data;
  } tx_word_t;

  typedef struct packed {
    logic        err;
    logic        cmd_sync;
    logic [15:0] data;
  } rx_word_t;

  typedef enum logic [1:0] {RX_HUNT, RX_SYNC2, RX_BITS} rx_state_t;

  typedef enum logic [2:0] {
    SEL_CTRL, SEL_STAT, SEL_TXA, SEL_TXB, SEL_RXA, SEL_RXB, SEL_NONE
  } reg_sel_t;

endpackage

// File: core/word_if.sv
`timescale 1ns/1ps
`default_nettype none
interface word_if #(parameter int W = 17);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: core/pair_buf.sv
`timescale 1ns/1ps
`default_nettype none
module pair_buf #(
  parameter int W     = 17,
  parameter int DEPTH = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  word_if.snk      up,
  word_if.src      dn
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } buf_st_t;

  buf_st_t s_reg;
  buf_st_t s_next;
  logic    push;
  logic    pop;

  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign up.ready = (s_reg.cnt != (AW+1)'(DEPTH));
  assign dn.valid = (s_reg.cnt != '0);
  assign dn.data  = s_reg.mem[s_reg.rp];
  assign push     = up.valid && up.ready;
  assign pop      = dn.valid && dn.ready;

  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wp] = up.data;
      s_next.wp            = step(s_reg.wp);
    end
    if (pop) begin
      s_next.rp = step(s_reg.rp);
    end
    s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule
`default_nettype wire

// File: core/biphase_tx.sv
`timescale 1ns/1ps
`default_nettype none
`include "xcvr_consts.svh"
module biphase_tx (
  input  wire logic  pclk,
  input  wire logic  presetn,
  input  wire logic  en,
  input  wire logic  block_in,
  word_if.snk        src,
  output logic [1:0] line_out,
  output logic       block_out,
  output logic       busy
);
  import xcvr_pkg::*;

  typedef struct packed {
    logic               act;
    logic [`HALVES-1:0] pat;
    logic [5:0]         half;
    logic [7:0]         tick;
    logic [1:0]         line;
    logic               blk;
  } tx_st_t;

  localparam tx_st_t RST = '{act: 1'b0, pat: '0, half: '0, tick: '0, line: 2'b00, blk: 1'b1};

  tx_st_t   s_reg;
  tx_st_t   s_next;
  tx_word_t w;
  logic     tick_end;
  logic     last;
  logic     take;

  // Sync, 16 data halves pairs, odd parity; a one is high then low
  function automatic logic [`HALVES-1:0] frame(input tx_word_t wd);
    logic [`HALVES-1:0] f;
    f = {(wd.cmd_sync ? `SYNC_CMD : `SYNC_DAT), 34'h0};
    for (int i = 0; i < 16; i++) begin
      f[33 - 2*i] = wd.data[15 - i];
      f[32 - 2*i] = ~wd.data[15 - i];
    end
    f[1] = ~^wd.data;
    f[0] = ^wd.data;
    return f;
  endfunction

  assign w         = tx_word_t'(src.data);
  assign tick_end  = (s_reg.tick == 8'(`HALF_CYC - 1));
  assign last      = s_reg.act && tick_end && (s_reg.half == 6'(`HALVES - 1));
  assign take      = src.valid && src.ready;
  assign src.ready = en && !block_in && (!s_reg.act || last); // [RL3]
  assign line_out  = s_reg.line;
  assign block_out = s_reg.blk;
  assign busy      = s_reg.act;

  always_comb begin
    s_next = s_reg;
    if (s_reg.act) begin
      s_next.tick = tick_end ? 8'h00 : s_reg.tick + 8'h01;
      if (tick_end) begin
        s_next.pat  = {s_reg.pat[`HALVES-2:0], 1'b0};
        s_next.half = s_reg.half + 6'h01;
      end
      if (last) begin
        s_next.act = 1'b0;
      end
    end
    // Next word follows with no dead time
    if (take) begin
      s_next.act  = 1'b1;
      s_next.pat  = frame(w);
      s_next.half = 6'h00;
      s_next.tick = 8'h00;
    end
    if (block_in) begin
      s_next.act = 1'b0; // [RL3] [RL9]
    end
    s_next.line = s_next.act ? {~s_next.pat[`HALVES-1], s_next.pat[`HALVES-1]} : 2'b00; // [RL5]
    s_next.blk  = !s_next.act; // [RL4]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= RST;
    end else begin
      s_reg <= s_next;
    end
  end

  sequence s_start;
    take && !block_in;
  endsequence

  property p_sync_start;
    @(posedge pclk) disable iff (!presetn)
    s_start |=> line_out == ($past(w.cmd_sync) ? 2'b01 : 2'b10);
  endproperty
  a_sync_start: assert property (p_sync_start) else $error("sync half wrong"); // [RL5]

  property p_idle_blk;
    @(posedge pclk) disable iff (!presetn)
    $fell(busy) |-> block_out && line_out == 2'b00;
  endproperty
  a_idle_blk: assert property (p_idle_blk) else $error("idle not inhibited"); // [RL4]

  property p_inhibit;
    @(posedge pclk) disable iff (!presetn)
    block_in |=> !busy && block_out && line_out == 2'b00;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibit ignored"); // [RL9]

  property p_no_take;
    @(posedge pclk) disable iff (!presetn)
    block_in |-> !src.ready;
  endproperty
  a_no_take: assert property (p_no_take) else $error("word taken while blocked"); // [RL3]
endmodule
`default_nettype wire

// File: core/xcvr_if_top.sv
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "xcvr_consts.svh"
// What this block and its integrator do
// RL1: Strap low makes the decoder take single-ended receive lines.
// RL2: Strap high makes the decoder take double-ended biphase receive pairs.
// RL3: Per channel, low inhibit input enables transmit, high forces it off.
// RL4: Inhibit output is high whenever the channel is not transmitting.
// RL5: Outgoing words leave as biphase transmit data on an output pair.
// RL6: Biphase receive data is taken on an input pair per channel.
// RL7: Loop pairs are joined for internal transceivers, split for external ones.
// RL8: Integrator routes each inhibit output to the external transceiver's inhibit.
// RL9: While inhibit input is high, transmit pair idles and inhibit output stays high.
module xcvr_if_top #(
  parameter int BUF_DEPTH = 2
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        decoder_input_style_strap,
  input  wire logic        chan_a_xmit_block_in,
  input  wire logic        chan_b_xmit_block_in,
  output logic             chan_a_xmit_block_out,
  output logic             chan_b_xmit_block_out,
  output logic      [1:0]  chan_a_tx_line_out,
  output logic      [1:0]  chan_b_tx_line_out,
  input  wire logic [1:0]  chan_a_rx_line_in,
  input  wire logic [1:0]  chan_b_rx_line_in
);
  import xcvr_pkg::*;

  localparam int TXW = $bits(tx_word_t);

  typedef struct packed {
    logic [6:0]       s1;
    logic [6:0]       s2;
    logic [6:0]       s3;
    logic [6:0]       f;
    logic [1:0]       ctrl;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    rx_state_t [1:0]  rxs;
    logic [1:0][7:0]  run;
    logic [1:0][7:0]  tmr;
    logic [1:0][4:0]  nb;
    logic [1:0][16:0] sh;
    logic [1:0]       first;
    logic [1:0]       cmd;
    logic [1:0]       err;
    logic [1:0]       prev;
    logic [1:0]       prev_ok;
    rx_word_t [1:0]   rxw;
    logic [1:0]       rxv;
    logic [1:0]       ovr;
    logic [1:0]       fresh;
  } top_st_t;

  localparam top_st_t RST = '{s1: `PIN_RST, s2: `PIN_RST, s3: `PIN_RST, f: `PIN_RST,
                              ctrl: `CTRL_RST, rxs: {RX_HUNT, RX_HUNT}, default: '0};

  top_st_t         s_reg;
  top_st_t         s_next;
  reg_sel_t        sel;
  logic            acc;
  logic            done;
  logic            go;
  logic            style;
  logic [6:0]      agree;
  logic [1:0]      lvl;
  logic [1:0]      ok;
  logic [1:0]      pop;
  logic [1:0]      fin;
  logic [1:0]      tx_push;
  logic [1:0]      tx_rdy;
  logic [1:0]      tx_busy;
  logic [1:0]      blk_o;
  logic [1:0][1:0] line_o;
  logic [16:0]     nsh;

  function automatic reg_sel_t decode(input logic [7:0] a);
    case (a)
      `OFF_CTRL: decode = SEL_CTRL;
      `OFF_STAT: decode = SEL_STAT;
      `OFF_TXA:  decode = SEL_TXA;
      `OFF_TXB:  decode = SEL_TXB;
      `OFF_RXA:  decode = SEL_RXA;
      `OFF_RXB:  decode = SEL_RXB;
      default:   decode = SEL_NONE;
    endcase
  endfunction

  assign sel   = decode(paddr);
  assign acc   = psel && penable;
  assign done  = acc && s_reg.pready;
  assign style = s_reg.f[`PIN_STYLE];
  // Stall a transmit write while that channel's buffer is full
  assign go    = !(pwrite && ((sel == SEL_TXA && !tx_rdy[0]) || (sel == SEL_TXB && !tx_rdy[1])));
  assign agree = ~(s_reg.s2 ^ s_reg.s3);

  assign prdata                = s_reg.prdata;
  assign pready                = s_reg.pready;
  assign pslverr               = s_reg.pslverr;
  assign chan_a_tx_line_out    = line_o[0];
  assign chan_b_tx_line_out    = line_o[1];
  assign chan_a_xmit_block_out = blk_o[0];
  assign chan_b_xmit_block_out = blk_o[1];

  always_comb begin
    s_next  = s_reg;
    tx_push = 2'b00;
    pop     = 2'b00;
    fin     = 2'b00;
    lvl     = 2'b00;
    ok      = 2'b00;
    nsh     = '0;
    s_next.s1 = {chan_b_rx_line_in, chan_a_rx_line_in, chan_b_xmit_block_in,
                 chan_a_xmit_block_in, decoder_input_style_strap};
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
    s_next.f  = (agree & s_reg.s3) | (~agree & s_reg.f);

    s_next.pready  = acc && !s_reg.pready && go;
    s_next.pslverr = s_next.pready && (sel == SEL_NONE);
    if (s_next.pready) begin
      case (sel)
        SEL_CTRL: s_next.prdata = {30'h0, s_reg.ctrl};
        SEL_STAT: s_next.prdata = {23'h0, s_reg.ovr, s_reg.rxv, tx_busy, s_reg.f[2:1], style};
        SEL_RXA: begin
          s_next.prdata   = {12'h0, s_reg.ovr[0], s_reg.rxv[0], s_reg.rxw[0]};
          s_next.fresh[0] = 1'b0;
        end
        SEL_RXB: begin
          s_next.prdata   = {12'h0, s_reg.ovr[1], s_reg.rxv[1], s_reg.rxw[1]};
          s_next.fresh[1] = 1'b0;
        end
        default: s_next.prdata = 32'h0;
      endcase
    end
    if (done && !s_reg.pslverr) begin
      case (sel)
        SEL_CTRL: begin
          if (pwrite) begin
            s_next.ctrl = pwdata[1:0];
          end
        end
        SEL_TXA: tx_push[0] = pwrite;
        SEL_TXB: tx_push[1] = pwrite;
        SEL_RXA: pop[0] = !pwrite;
        SEL_RXB: pop[1] = !pwrite;
        default: ;
      endcase
    end

    for (int c = 0; c < 2; c++) begin
      // A word that landed after the read was captured survives the pop
      if (pop[c] && !s_reg.fresh[c]) begin
        s_next.rxv[c] = 1'b0;
        s_next.ovr[c] = 1'b0;
      end
      lvl[c] = s_reg.f[`PIN_RX + 2*c];
      ok[c]  = !style || (s_reg.f[`PIN_RX + 2*c] ^ s_reg.f[`PIN_RX + 2*c + 1]); // [RL1] [RL2]
      nsh    = {s_reg.sh[c][15:0], s_reg.first[c]};
      case (s_reg.rxs[c])
        RX_HUNT: begin
          if (!ok[c]) begin
            s_next.run[c] = 8'h00;
          end else if (lvl[c] == s_reg.prev[c]) begin
            s_next.run[c] = (s_reg.run[c] == 8'hff) ? 8'hff : s_reg.run[c] + 8'h01;
          end else begin
            if (s_reg.prev_ok[c] && s_reg.run[c] >= 8'(`SYNC_CYC - `SYNC_TOL) &&
                s_reg.run[c] <= 8'(`SYNC_CYC + `HALF_CYC)) begin
              s_next.rxs[c] = RX_SYNC2;
              s_next.cmd[c] = s_reg.prev[c];
              s_next.tmr[c] = 8'h00;
              s_next.err[c] = 1'b0;
            end
            s_next.run[c] = 8'h00;
          end
        end
        RX_SYNC2: begin
          s_next.tmr[c] = s_reg.tmr[c] + 8'h01;
          if (s_reg.tmr[c] == 8'(`SYNC_CYC / 2) && (lvl[c] == s_reg.cmd[c] || !ok[c])) begin
            s_next.rxs[c] = RX_HUNT; // [RL6]
          end else if (s_reg.tmr[c] == 8'(`SYNC_CYC - 1)) begin
            s_next.rxs[c] = RX_BITS;
            s_next.tmr[c] = 8'h00;
            s_next.nb[c]  = 5'h00;
          end
        end
        RX_BITS: begin
          s_next.tmr[c] = (s_reg.tmr[c] == 8'(2 * `HALF_CYC - 1)) ? 8'h00 : s_reg.tmr[c] + 8'h01;
          if (s_reg.tmr[c] == 8'(`HALF_CYC / 2)) begin
            s_next.first[c] = lvl[c];
            s_next.err[c]   = s_reg.err[c] || !ok[c];
          end else if (s_reg.tmr[c] == 8'(`HALF_CYC + `HALF_CYC / 2)) begin
            // Both halves equal is a biphase violation
            s_next.err[c] = s_reg.err[c] || !ok[c] || (lvl[c] == s_reg.first[c]);
            s_next.sh[c]  = nsh;
            s_next.nb[c]  = s_reg.nb[c] + 5'h01;
            if (s_reg.nb[c] == `LAST_BIT) begin
              fin[c]        = 1'b1;
              s_next.rxs[c] = RX_HUNT;
              s_next.run[c] = 8'h00;
            end
          end
        end
        default: s_next.rxs[c] = RX_HUNT;
      endcase
      s_next.prev[c]    = lvl[c];
      s_next.prev_ok[c] = ok[c];
      if (fin[c]) begin
        s_next.rxw[c] = '{err: s_next.err[c] || !(^nsh), cmd_sync: s_reg.cmd[c],
                          data: nsh[16:1]}; // [RL6]
        s_next.ovr[c]   = s_next.ovr[c] || s_next.rxv[c];
        s_next.rxv[c]   = 1'b1;
        s_next.fresh[c] = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= RST;
    end else begin
      s_reg <= s_next;
    end
  end

  word_if #(.W(TXW)) txin [2] ();
  word_if #(.W(TXW)) txout [2] ();

  generate
    for (genvar c = 0; c < 2; c++) begin : g_ch
      assign txin[c].valid = tx_push[c];
      assign txin[c].data  = pwdata[TXW-1:0];
      assign tx_rdy[c]     = txin[c].ready;

      pair_buf #(
        .W     (TXW),
        .DEPTH (BUF_DEPTH)
      ) u_buf (
        .pclk    (pclk),
        .presetn (presetn),
        .up      (txin[c]),
        .dn      (txout[c])
      );

      biphase_tx u_tx (
        .pclk      (pclk),
        .presetn   (presetn),
        .en        (s_reg.ctrl[c]),
        .block_in  (s_reg.f[`PIN_BLK + c]), // [RL3]
        .src       (txout[c]),
        .line_out  (line_o[c]), // [RL5]
        .block_out (blk_o[c]),
        .busy      (tx_busy[c])
      );
    end
  endgenerate

  sequence s_strap_low;
    (!decoder_input_style_strap) [*5];
  endsequence

  sequence s_strap_high;
    decoder_input_style_strap [*5];
  endsequence

  property p_single_end;
    @(posedge pclk) disable iff (!presetn)
    s_strap_low |-> !style && ok == 2'b11;
  endproperty
  a_single_end: assert property (p_single_end) else $error("single-ended not chosen"); // [RL1]

  property p_double_end;
    @(posedge pclk) disable iff (!presetn)
    s_strap_high |-> style;
  endproperty
  a_double_end: assert property (p_double_end) else $error("double-ended not chosen"); // [RL2]

  property p_block_a;
    @(posedge pclk) disable iff (!presetn)
    chan_a_xmit_block_in [*5] |=> chan_a_xmit_block_out && chan_a_tx_line_out == 2'b00;
  endproperty
  a_block_a: assert property (p_block_a) else $error("channel a not shut down"); // [RL3]

  property p_rx_word;
    @(posedge pclk) disable iff (!presetn)
    fin[0] |=> s_reg.rxv[0] && s_reg.rxw[0].cmd_sync == $past(s_reg.cmd[0]);
  endproperty
  a_rx_word: assert property (p_rx_word) else $error("received word not stored"); // [RL6]
endmodule
`default_nettype wire

// File: sim/xcvr_model.sv
`timescale 1ns/1ps
`default_nettype none
// External transceiver: the bus echoes back into its own receiver
module xcvr_model #(
  parameter int LAG = 1
) (
  input  wire logic       clk,
  input  wire logic       single_ended,
  input  wire logic       xmit_block,
  input  wire logic [1:0] tx_line,
  output logic      [1:0] rx_line
);
  logic [1:0] bus_q [4] = '{default: 2'h0};
  logic       junk      = 1'b0;

  always @(posedge clk) begin
    bus_q[0] <= xmit_block ? 2'h0 : tx_line;
    for (int i = 1; i < 4; i++) begin
      bus_q[i] <= bus_q[i-1];
    end
    junk <= ~junk;
  end

  // Fiber receiver leaves the negative line floating
  assign rx_line = single_ended ? {junk, bus_q[LAG][0]} : bus_q[LAG];
endmodule
`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "xcvr_consts.svh"
module tb_top;
  localparam int WORD = `HALVES * `HALF_CYC;
  localparam logic [32:0] RXM = 33'h1_000f_ffff;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        strap, blk_a, blk_b, bo_a, bo_b;
  logic [1:0]  tx_a, tx_b, rx_a, rx_b;
  logic [65:0] notes[$];
  logic [65:0] note;
  int          err_count, compares;

  // Loop pairs kept apart, inhibit outputs routed to the transceivers
  xcvr_if_top i_xcvr_if_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .decoder_input_style_strap(strap), .chan_a_xmit_block_in(blk_a),
    .chan_b_xmit_block_in(blk_b), .chan_a_xmit_block_out(bo_a), .chan_b_xmit_block_out(bo_b),
    .chan_a_tx_line_out(tx_a), .chan_b_tx_line_out(tx_b), .chan_a_rx_line_in(rx_a),
    .chan_b_rx_line_in(rx_b));
  xcvr_model #(.LAG(1)) i_xcvr_model_a (.clk(pclk), .single_ended(~strap),
    .xmit_block(bo_a), .tx_line(tx_a), .rx_line(rx_a));
  xcvr_model #(.LAG(3)) i_xcvr_model_b (.clk(pclk), .single_ended(~strap),
    .xmit_block(bo_b), .tx_line(tx_b), .rx_line(rx_b));

  always #5 pclk = ~pclk;

  task automatic close_out();
    check("unread notes", 33'(notes.size()), 33'h0);
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic fail_wait(input string what);
    err_count++;
    $display("mismatch %s expected done seen timeout", what);
    close_out();
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) fail_wait("pready");
    @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] exp, input logic [32:0] mask);
    notes.push_back({mask, exp});
    apb(a, 1'b0, 32'h0);
  endtask

  // Wait until a channel's inhibit output reaches lvl, counting cycles
  task automatic wait_blk(input logic ch, input logic lvl, input int lim, output int n);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while ((ch ? bo_b : bo_a) !== lvl && n < lim);
    if ((ch ? bo_b : bo_a) !== lvl) fail_wait("inhibit output");
  endtask

  always @(negedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (notes.size() == 0) begin
        fail_wait("read note");
      end else begin
        note = notes.pop_front();
        check("apb read", {pslverr, prdata} & note[65:33], note[32:0]);
      end
    end
  end

  initial begin
    int          n;
    logic [16:0] w [2];
    pclk      = 1'b0;
    presetn   = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0;
    strap     = 1'b1;
    blk_a     = 1'b0;
    blk_b     = 1'b0;
    err_count = 0;
    compares  = 0;
    void'($urandom(66));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check("idle pins", {27'h0, bo_b, bo_a, tx_b, tx_a}, 33'h30);
    repeat (6) @(posedge pclk);
    rd(`OFF_CTRL, 33'h0, 33'h1_0000_0003);
    rd(`OFF_STAT, 33'h1, 33'h1_0000_01ff);
    rd(8'h20, 33'h1_0000_0000, 33'h1_ffff_ffff);
    apb(`OFF_STAT, 1'b1, 32'h1fe);
    rd(`OFF_STAT, 33'h1, 33'h1_0000_01ff);
    apb(`OFF_CTRL, 1'b1, 32'h3);
    for (int s = 1; s >= 0; s--) begin
      @(posedge pclk);
      strap <= s[0];
      repeat (8) @(posedge pclk);
      rd(`OFF_STAT, {32'h0, s[0]}, 33'h1_0000_0001);
      repeat (3) begin
        w[0] = 17'($urandom);
        w[1] = 17'($urandom);
        // Single-ended idle reads as a low half: only command syncs show after idle
        w[0][16] = w[0][16] | !s[0];
        w[1][16] = w[1][16] | !s[0];
        apb(`OFF_TXB, 1'b1, {15'h0, w[1]});
        apb(`OFF_TXA, 1'b1, {15'h0, w[0]});
        wait_blk(1'b0, 1'b0, 20, n);
        wait_blk(1'b0, 1'b1, WORD + 10, n);
        check("word cycles", 33'(n), 33'(WORD));
        repeat (60) @(posedge pclk);
        rd(`OFF_RXA, {13'h0, 3'b010, w[0]}, RXM);
        rd(`OFF_RXB, {13'h0, 3'b010, w[1]}, RXM);
      end
    end
    // Two queued words leave without a gap; the unread first is overrun
    w[0] = 17'($urandom) | 17'h1_0000;
    w[1] = 17'($urandom);
    apb(`OFF_CTRL, 1'b1, 32'h2);
    apb(`OFF_TXA, 1'b1, {15'h0, w[0]});
    apb(`OFF_TXA, 1'b1, {15'h0, w[1]});
    repeat (20) @(posedge pclk);
    @(negedge pclk);
    check("held by enable", {32'h0, bo_a}, 33'h1);
    apb(`OFF_CTRL, 1'b1, 32'h3);
    wait_blk(1'b0, 1'b0, 20, n);
    wait_blk(1'b0, 1'b1, 2 * WORD + 10, n);
    check("queued cycles", 33'(n), 33'(2 * WORD));
    repeat (60) @(posedge pclk);
    rd(`OFF_RXA, {13'h0, 3'b110, w[1]}, RXM);
    // Inhibit input raised in mid-word
    apb(`OFF_TXA, 1'b1, {15'h0, w[0]});
    wait_blk(1'b0, 1'b0, 20, n);
    repeat (300) @(posedge pclk);
    blk_a <= 1'b1;
    blk_b <= 1'b1;
    wait_blk(1'b0, 1'b1, 8, n);
    apb(`OFF_TXA, 1'b1, {15'h0, w[1]});
    apb(`OFF_TXB, 1'b1, {15'h0, w[0]});
    repeat (200) @(posedge pclk);
    @(negedge pclk);
    check("blocked pins", {27'h0, bo_b, tx_b, bo_a, tx_a}, 33'h24);
    rd(`OFF_STAT, 33'h6, 33'h1_0000_0007);
    @(posedge pclk);
    blk_a <= 1'b0;
    blk_b <= 1'b0;
    wait_blk(1'b0, 1'b0, 20, n);
    check("resumed line", {31'h0, tx_a !== 2'h0, bo_a}, 33'h2);
    wait_blk(1'b1, 1'b0, 20, n);
    check("resumed line b", {31'h0, tx_b !== 2'h0, bo_b}, 33'h2);
    wait_blk(1'b0, 1'b1, WORD + 10, n);
    // Reset in mid-word drops the line at once
    apb(`OFF_TXA, 1'b1, {15'h0, w[0]});
    wait_blk(1'b0, 1'b0, 20, n);
    repeat (50) @(posedge pclk);
    presetn <= 1'b0;
    @(negedge pclk);
    check("reset pins", {27'h0, bo_b, bo_a, tx_b, tx_a}, 33'h30);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check("released pins", {27'h0, bo_b, bo_a, tx_b, tx_a}, 33'h30);
    rd(`OFF_CTRL, 33'h0, 33'h1_0000_0003);
    close_out();
  end
endmodule
`default_nettype wire
